// File: design/dceq_channel_ctrl.sv
`timescale 1ns/1ps
`include "dceq_params.svh"
module dceq_channel_ctrl #(
  parameter int N_REG   = 2,
  parameter int Q_DEPTH = `DCEQ_Q_DEPTH,
  parameter int CW      = $clog2(Q_DEPTH) + 1
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [63:0]           ext_event,
  input  wire logic [63:0]           ext_enable,
  input  wire logic [N_REG*64-1:0]   man_set,
  input  wire logic [N_REG*64-1:0]   region_dmask,
  input  wire logic [N_REG*64-1:0]   region_imask,
  input  wire logic [63:0]           event_clr,
  input  wire logic [7:0]            quick_clr,
  input  wire logic [7:0]            quick_enable,
  input  wire logic [71:0]           missed_clr,
  input  wire logic [127:0]          chan_queue,
  input  wire logic [15:0]           quick_queue,
  input  wire logic [8:0]            queue_prio,
  input  wire logic [3*CW-1:0]       queue_thresh,
  input  wire logic [55:0]           qmap_set,
  input  wire logic [23:0]           qmap_word,
  input  wire logic [63:0]           int_enable,
  input  wire logic [63:0]           ipr_clr,
  input  wire logic [4:0]            err_clr,
  input  wire logic                  wr_en,
  input  wire logic [6:0]            wr_set,
  input  wire logic [2:0]            wr_word,
  input  dceq_pkg::dceq_word_t       wr_data,
  input  wire logic [2:0]            mc_ready,
  input  wire logic [2:0]            cmpl_valid,
  input  wire logic [17:0]           cmpl_code,
  input  wire logic [2:0]            cmpl_int_en,
  input  wire logic [2:0]            cmpl_chain_en,
  output logic      [63:0]           event_status,
  output logic      [7:0]            quick_status,
  output logic      [71:0]           missed_status,
  output logic      [63:0]           ipr_status,
  output logic      [4:0]            err_status,
  output logic                       err_irq,
  output logic      [N_REG-1:0]      cpl_irq,
  output logic      [3*CW-1:0]       queue_count,
  output logic      [2:0]            mc_valid,
  output logic      [767:0]          mc_word
);
  import dceq_pkg::*;
  localparam int PW  = $clog2(Q_DEPTH);
  localparam int NCH = `DCEQ_N_EVT + `DCEQ_N_QCK;

  function automatic logic [7:0] dceq_first(input logic [71:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] dceq_qsel(input logic [1:0] q);
    return (q == 2'h3) ? 2'h2 : q;
  endfunction

  logic [63:0]      ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic [NCH-1:0]   stat_reg, stat_next, missed_reg, missed_next;
  logic [63:0]      ipr_reg, ipr_next;
  logic [4:0]       err_reg, err_next;
  logic             err_irq_reg, err_irq_next;
  logic [N_REG-1:0] irq_reg, irq_next;
  dceq_word_t       mem_reg [`DCEQ_N_SET][`DCEQ_N_WORD];
  dceq_word_t       mem_next [`DCEQ_N_SET][`DCEQ_N_WORD];
  dceq_entry_s      fifo_reg [3][Q_DEPTH];
  dceq_entry_s      fifo_next [3][Q_DEPTH];
  logic [PW-1:0]    wp_reg [3], wp_next [3], rp_reg [3], rp_next [3];
  logic [CW-1:0]    cnt_reg [3], cnt_next [3];
  logic [2:0]       mcv_reg, mcv_next;
  dceq_word_t       mcw_reg [3][`DCEQ_N_WORD];
  dceq_word_t       mcw_next [3][`DCEQ_N_WORD];

  logic [NCH-1:0]   new_evt, elig, enq_mask;
  logic [63:0]      ext_rise, man_any, chain_evt, cpl_int;
  logic [7:0]       quick_hit, pick;
  logic [1:0]       chq [NCH];
  logic [2:0]       full;
  logic             enq_v;
  logic [1:0]       enq_q;
  logic             deq, found, is_null, is_dummy, early;
  logic [1:0]       sq;
  dceq_entry_s      head;
  logic [6:0]       set_i;
  dceq_word_t       hw [`DCEQ_N_WORD];
  logic [15:0]      acnt, bcnt, ccnt, link;
  logic [5:0]       tcc;

  // Event detection, status, missed flags and enqueue arbitration
  always_comb begin
    ext_rise = ext_s2_reg & ~ext_s3_reg & ext_enable;
    man_any  = 64'h0;
    for (int r = 0; r < N_REG; r++) begin
      man_any = man_any | (man_set[r*64+:64] & region_dmask[r*64+:64]);
    end
    for (int k = 0; k < `DCEQ_N_QCK; k++) begin
      quick_hit[k] = quick_enable[k] && wr_en && wr_set == qmap_set[k*7+:7]
                     && wr_word == qmap_word[k*3+:3];
    end
    new_evt = {quick_hit, ext_rise | man_any | chain_evt};
    for (int q = 0; q < 3; q++) begin
      full[q] = cnt_reg[q] == CW'(Q_DEPTH);
    end
    for (int i = 0; i < NCH; i++) begin
      chq[i]  = (i < 64) ? dceq_qsel(chan_queue[2*i+:2])
                         : dceq_qsel(quick_queue[2*(i-64)+:2]);
      elig[i] = stat_reg[i] && !full[chq[i]];
    end
    pick     = dceq_first(elig);
    enq_v    = pick[7];
    enq_q    = chq[pick[6:0]];
    enq_mask = '0;
    if (enq_v) begin
      enq_mask[pick[6:0]] = 1'b1;
    end
    // A new event wins over a clear or enqueue in the same cycle
    stat_next   = (stat_reg & ~{quick_clr, event_clr} & ~enq_mask) | new_evt;
    missed_next = (missed_reg & ~missed_clr) | (new_evt & stat_reg & ~enq_mask);
  end

  // Queue head selection and set check
  always_comb begin
    found = 1'b0;
    sq    = 2'h0;
    for (int q = 0; q < 3; q++) begin
      if (cnt_reg[q] != '0 && !mcv_reg[q]
          && (!found || queue_prio[q*3+:3] < queue_prio[sq*3+:3])) begin
        found = 1'b1;
        sq    = 2'(q);
      end
    end
    deq      = found;
    head     = fifo_reg[sq][rp_reg[sq]];
    set_i    = head.quick ? qmap_set[head.chan[2:0]*7+:7] : {1'b0, head.chan};
    hw       = mem_reg[set_i];
    acnt     = hw[`DCEQ_W_CNT][15:0];
    bcnt     = hw[`DCEQ_W_CNT][31:16];
    ccnt     = hw[`DCEQ_W_CCNT][15:0];
    link     = hw[`DCEQ_W_LINK][15:0];
    tcc      = hw[`DCEQ_W_OPT][`DCEQ_OPT_TCC_LO+:6];
    is_null  = deq && acnt == 16'h0 && bcnt == 16'h0 && ccnt == 16'h0;
    is_dummy = deq && !is_null && (acnt == 16'h0 || bcnt == 16'h0 || ccnt == 16'h0);
    early    = deq && !is_null && !is_dummy && hw[`DCEQ_W_OPT][`DCEQ_OPT_EARLY];
  end

  // Queue storage
  always_comb begin
    fifo_next = fifo_reg;
    wp_next   = wp_reg;
    rp_next   = rp_reg;
    cnt_next  = cnt_reg;
    for (int q = 0; q < 3; q++) begin
      if (enq_v && enq_q == 2'(q)) begin
        fifo_next[q][wp_reg[q]] = {pick[6], pick[5:0]};
        wp_next[q]              = wp_reg[q] + 1'b1;
      end
      if (deq && sq == 2'(q)) begin
        rp_next[q] = rp_reg[q] + 1'b1;
      end
      cnt_next[q] = cnt_reg[q] + CW'(enq_v && enq_q == 2'(q)) - CW'(deq && sq == 2'(q));
    end
  end

  // Move command slots, set memory writes and linking
  always_comb begin
    mcv_next = mcv_reg & ~mc_ready;
    mcw_next = mcw_reg;
    mem_next = mem_reg;
    if (deq && !is_null && !is_dummy) begin
      mcv_next[sq] = 1'b1;
      mcw_next[sq] = hw;
      if (!hw[`DCEQ_W_OPT][`DCEQ_OPT_SYNCDIM]) begin
        mcw_next[sq][`DCEQ_W_CNT][31:16] = `DCEQ_ONE_ARRAY;
      end
    end
    if (deq && !is_null && link != `DCEQ_LINK_NULL) begin
      mem_next[set_i] = mem_reg[link[`DCEQ_LINK_SET_LO+:7]];
    end
    if (wr_en) begin
      mem_next[wr_set][wr_word] = wr_data;
    end
  end

  // Completion, chaining, interrupts and errors
  always_comb begin
    cpl_int   = 64'h0;
    chain_evt = 64'h0;
    for (int q = 0; q < 3; q++) begin
      if (cmpl_valid[q]) begin
        cpl_int[cmpl_code[q*6+:6]]   = cpl_int[cmpl_code[q*6+:6]] | cmpl_int_en[q];
        chain_evt[cmpl_code[q*6+:6]] = chain_evt[cmpl_code[q*6+:6]] | cmpl_chain_en[q];
      end
    end
    if (early) begin
      cpl_int[tcc]   = cpl_int[tcc] | hw[`DCEQ_W_OPT][`DCEQ_OPT_TCINTEN];
      chain_evt[tcc] = chain_evt[tcc] | hw[`DCEQ_W_OPT][`DCEQ_OPT_TCCHEN];
    end
    ipr_next = (ipr_reg & ~ipr_clr) | cpl_int;
    for (int r = 0; r < N_REG; r++) begin
      irq_next[r] = |(ipr_reg & int_enable & region_imask[r*64+:64]);
    end
    err_next = err_reg & ~err_clr;
    err_next[0] = err_next[0] | (|(new_evt & stat_reg & ~enq_mask));
    for (int q = 0; q < 3; q++) begin
      err_next[q+1] = err_next[q+1] | (cnt_reg[q] > queue_thresh[q*CW+:CW]);
    end
    err_next[4]  = err_next[4] | is_null;
    err_irq_next = |err_reg;
  end

  always_ff @(posedge clk) begin
    ext_s1_reg <= ext_event;
    ext_s2_reg <= ext_s1_reg;
    ext_s3_reg <= ext_s2_reg;
    mem_reg    <= mem_next;
    fifo_reg   <= fifo_next;
    mcw_reg    <= mcw_next;
    if (sys_rst) begin
      stat_reg    <= '0;
      missed_reg  <= '0;
      ipr_reg     <= 64'h0;
      err_reg     <= `DCEQ_ERR_RST;
      err_irq_reg <= 1'b0;
      irq_reg     <= '0;
      mcv_reg     <= 3'h0;
      for (int q = 0; q < 3; q++) begin
        wp_reg[q]  <= '0;
        rp_reg[q]  <= '0;
        cnt_reg[q] <= '0;
      end
    end else begin
      stat_reg    <= stat_next;
      missed_reg  <= missed_next;
      ipr_reg     <= ipr_next;
      err_reg     <= err_next;
      err_irq_reg <= err_irq_next;
      irq_reg     <= irq_next;
      mcv_reg     <= mcv_next;
      wp_reg      <= wp_next;
      rp_reg      <= rp_next;
      cnt_reg     <= cnt_next;
    end
  end

  always_comb begin
    event_status  = stat_reg[63:0];
    quick_status  = stat_reg[71:64];
    missed_status = missed_reg;
    ipr_status    = ipr_reg;
    err_status    = err_reg;
    err_irq       = err_irq_reg;
    cpl_irq       = irq_reg;
    mc_valid      = mcv_reg;
    for (int q = 0; q < 3; q++) begin
      queue_count[q*CW+:CW] = cnt_reg[q];
      for (int w = 0; w < `DCEQ_N_WORD; w++) begin
        mc_word[q*256+w*32+:32] = mcw_reg[q][w];
      end
    end
  end
endmodule

// File: include/dceq_params.svh
`ifndef DCEQ_PARAMS_SVH
`define DCEQ_PARAMS_SVH
`define DCEQ_N_EVT       64
`define DCEQ_N_QCK       8
`define DCEQ_N_SET       128
`define DCEQ_N_WORD      8
`define DCEQ_N_Q         3
`define DCEQ_Q_DEPTH     16
`define DCEQ_W_OPT       0
`define DCEQ_W_CNT       2
`define DCEQ_W_LINK      5
`define DCEQ_W_CCNT      7
`define DCEQ_OPT_SYNCDIM 2
`define DCEQ_OPT_EARLY   11
`define DCEQ_OPT_TCC_LO  12
`define DCEQ_OPT_TCINTEN 20
`define DCEQ_OPT_TCCHEN  22
`define DCEQ_LINK_NULL   16'hffff
`define DCEQ_LINK_SET_LO 5
`define DCEQ_ONE_ARRAY   16'h0001
`define DCEQ_ERR_RST     5'h00
`endif

// File: include/dceq_pkg.sv
package dceq_pkg;
  typedef logic [31:0] dceq_word_t;
  typedef struct packed {
    logic       quick;
    logic [5:0] chan;
  } dceq_entry_s;
endpackage

// File: bench/dceq_props.sv
`timescale 1ns/1ps
module dceq_props #(
  parameter int N_REG   = 2,
  parameter int Q_DEPTH = 16,
  parameter int CW      = 5
) (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic [N_REG*64-1:0]  man_set,
  input wire logic [N_REG*64-1:0]  region_dmask,
  input wire logic [N_REG*64-1:0]  region_imask,
  input wire logic [63:0]          int_enable,
  input wire logic [3*CW-1:0]      queue_thresh,
  input wire logic [2:0]           mc_ready,
  input wire logic [2:0]           cmpl_valid,
  input wire logic [17:0]          cmpl_code,
  input wire logic [2:0]           cmpl_int_en,
  input wire logic [2:0]           cmpl_chain_en,
  input wire logic [63:0]          event_status,
  input wire logic [63:0]          ipr_status,
  input wire logic [4:0]           err_status,
  input wire logic                 err_irq,
  input wire logic [N_REG-1:0]     cpl_irq,
  input wire logic [3*CW-1:0]      queue_count,
  input wire logic [2:0]           mc_valid,
  input wire logic [767:0]         mc_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic cpl_exp_reg;
  always_ff @(posedge clk) begin
    cpl_exp_reg <= |(ipr_status & int_enable & region_imask[63:0]);
  end
  property p_man_rec; man_set[5] && region_dmask[5] |=> event_status[5]; endproperty
  a_man_rec: assert property (p_man_rec) else $error("manual event not recorded");
  property p_err_irq; 1'b1 |=> err_irq == (|$past(err_status)); endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq mismatch");
  property p_mc_hold; mc_valid[0] && !mc_ready[0] |=> mc_valid[0] && $stable(mc_word[31:0]);
  endproperty
  a_mc_hold: assert property (p_mc_hold) else $error("command dropped early");
  property p_cnt_max; queue_count[CW-1:0] <= Q_DEPTH; endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("queue over depth");
  property p_cpl; cpl_irq[0] == cpl_exp_reg; endproperty
  a_cpl: assert property (p_cpl) else $error("completion irq mismatch");
  property p_ipr; cmpl_valid[0] && cmpl_int_en[0] |=> ipr_status[$past(cmpl_code[5:0])];
  endproperty
  a_ipr: assert property (p_ipr) else $error("completion not pending");
  property p_chain; cmpl_valid[0] && cmpl_chain_en[0] |=> event_status[$past(cmpl_code[5:0])];
  endproperty
  a_chain: assert property (p_chain) else $error("chain not raised");
  property p_thresh; queue_count[CW-1:0] > queue_thresh[CW-1:0] |=> err_status[1]; endproperty
  a_thresh: assert property (p_thresh) else $error("threshold error missing");
endmodule
bind dceq_channel_ctrl dceq_props #(.N_REG(N_REG), .Q_DEPTH(Q_DEPTH), .CW(CW)) i_props (.*);

// File: bench/dceq_engine_model.sv
`timescale 1ns/1ps
module dceq_engine_model (
  input  wire logic         clk,
  input  wire logic         slow,
  input  wire logic [2:0]   mc_valid,
  input  wire logic [767:0] mc_word,
  output logic      [2:0]   mc_ready,
  output logic      [2:0]   cmpl_valid,
  output logic      [17:0]  cmpl_code,
  output logic      [2:0]   cmpl_int_en,
  output logic      [2:0]   cmpl_chain_en
);
  logic [1:0]  wait_cnt [3];
  logic [31:0] opt;
  initial begin
    {mc_ready, cmpl_valid, cmpl_code, cmpl_int_en, cmpl_chain_en} = '0;
    wait_cnt = '{2'h0, 2'h0, 2'h0};
  end
  // Engine q serves only command slot q
  always @(posedge clk) begin
    for (int q = 0; q < 3; q++) begin
      opt = mc_word[q*256 +: 32];
      cmpl_valid[q] <= 1'b0;
      if (mc_valid[q] && mc_ready[q]) begin
        mc_ready[q] <= 1'b0;
        wait_cnt[q] <= 2'h0;
        cmpl_valid[q] <= !opt[11];
        cmpl_code[q*6 +: 6] <= opt[17:12];
        cmpl_int_en[q] <= opt[20];
        cmpl_chain_en[q] <= opt[22];
      end else begin
        cmpl_code[q*6 +: 6] <= ~cmpl_code[q*6 +: 6];
        if (mc_valid[q] && (!slow || wait_cnt[q] == 2'h3)) begin
          mc_ready[q] <= 1'b1;
        end else if (mc_valid[q]) begin
          wait_cnt[q] <= wait_cnt[q] + 2'h1;
        end
      end
    end
  end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dceq_pkg::*;
  logic         clk, sys_rst, slow, wr_en, err_irq;
  logic [1:0]   cpl_irq;
  logic [2:0]   wr_word, mc_valid, mc_ready, cmpl_valid, cmpl_int_en, cmpl_chain_en;
  logic [4:0]   err_clr, err_status;
  logic [6:0]   wr_set;
  logic [7:0]   quick_clr, quick_enable, quick_status;
  logic [8:0]   queue_prio;
  logic [14:0]  queue_thresh, queue_count;
  logic [15:0]  quick_queue;
  logic [17:0]  cmpl_code;
  logic [23:0]  qmap_word;
  logic [55:0]  qmap_set;
  logic [63:0]  ext_event, ext_enable, event_clr, int_enable, ipr_clr, event_status, ipr_status;
  logic [71:0]  missed_clr, missed_status;
  logic [127:0] man_set, region_dmask, region_imask, chan_queue;
  logic [767:0] mc_word;
  dceq_word_t   wr_data;
  int           errors, cmp_count, cyc;
  dceq_channel_ctrl i_dut (.*);
  dceq_engine_model i_eng (.*);
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      finish_test();
    end
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [6:0] s, logic [2:0] w, logic [31:0] d);
    {wr_en, wr_set, wr_word, wr_data} = {1'b1, s, w, d};
    tick();
  endtask
  // Trigger word of a quick channel is written last
  task automatic prog(logic [6:0] s, logic [31:0] opt, logic [31:0] ab, logic [15:0] c);
    wr(s, 0, opt);
    wr(s, 2, ab);
    wr(s, 5, 32'h0000_ffff);
    wr(s, 7, {16'h0, c});
    wr_en = 0;
  endtask
  task automatic fire(logic [127:0] m);
    man_set = m;
    tick();
    man_set = '0;
  endtask
  task automatic wait_mc(int q);
    int n = 0;
    while (mc_valid[q] !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk({31'h0, mc_valid[q]}, 32'h1);
  endtask
  task automatic t_manual;
    prog(5, 32'h0050_9000, 32'h0002_0004, 16'h1);
    prog(9, 32'h0, 32'h0000_0004, 16'h1);
    fire(128'h20);
    chk({31'h0, event_status[5]}, 32'h1);
    wait_mc(0);
    chk(mc_word[31:0], 32'h0050_9000);
    chk(mc_word[95:64], 32'h0001_0004);
    tick(6);
    chk({29'h0, ipr_status[9], err_status[1], cpl_irq[0]}, 32'h7);
    {ipr_clr, err_clr} = '1;
    tick();
    {ipr_clr, err_clr} = '0;
    $display("t_manual done");
  endtask
  task automatic t_counts;
    prog(6, 32'h0, 32'h0, 16'h0);
    prog(7, 32'h0, 32'h0000_0004, 16'h1);
    fire(128'h80);
    tick(4);
    chk({28'h0, mc_valid, err_status[4]}, 32'h0);
    fire(128'h40);
    tick(4);
    chk({28'h0, mc_valid, err_status[4]}, 32'h1);
    $display("t_counts done");
  endtask
  task automatic t_prio;
    slow = 1;
    prog(1, 32'h0000_1000, 32'h0001_0004, 16'h1);
    prog(3, 32'h0000_3000, 32'h0001_0004, 16'h1);
    man_set = 128'ha;
    tick();
    man_set = 128'h8;
    tick();
    man_set = '0;
    chk({31'h0, missed_status[3]}, 32'h1);
    wait_mc(1);
    chk(mc_word[287:256], 32'h0000_1000);
    repeat (16) if (mc_word[287:256] !== 32'h0000_3000) tick();
    chk({mc_word[286:256], mc_valid[1]}, 32'h0000_6001);
    $display("t_prio done");
  endtask
  task automatic t_quick;
    prog(20, 32'h0000_4000, 32'h0001_0004, 16'h1);
    chk({31'h0, quick_status[0]}, 32'h1);
    wait_mc(2);
    chk(mc_word[543:512], 32'h0000_4000);
    $display("t_quick done");
  endtask
  task automatic t_ext;
    prog(2, 32'h0, 32'h0000_0004, 16'h1);
    ext_event[2] = 1'b1;
    repeat (6) if (event_status[2] !== 1'b1) tick();
    chk({31'h0, event_status[2]}, 32'h1);
    $display("t_ext done");
  endtask
  task automatic finish_test;
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {clk, sys_rst, slow, wr_en, wr_set, wr_word, wr_data} = {3'b010, 43'h0};
    {ext_event, ext_enable, event_clr, ipr_clr, man_set, missed_clr} = '0;
    {err_clr, quick_clr, queue_prio, errors, cmp_count} = '0;
    {region_dmask, region_imask, int_enable} = '1;
    {ext_enable[2], quick_enable, quick_queue} = {1'b1, 8'h01, 16'h0002};
    {qmap_set, qmap_word, chan_queue} = {56'd20, 24'd7, 128'h44};
    queue_thresh = {5'h1f, 5'h1f, 5'h00};
    tick(6);
    sys_rst = 0;
    tick(3);
    t_manual();
    t_counts();
    t_prio();
    t_quick();
    t_ext();
    finish_test();
  end
endmodule
